// ---- testbench/i2c_slave_register_access_test.sv ----
`timescale 1ns/100ps
module i2c_slave_register_access_test;
   import i2cm_pkg::*;
   localparam logic [2:0] PINS = 3'h3;
   logic mclk = 0, resetn = 0, cmd_start = 0, fast_mode = 0;
   i2cm_cmd_t cmd_kind = CMD_WRITE;
   logic [2:0] addr_sel = PINS;
   logic [7:0] reg_index = 8'h00, wr_data = 8'h00, rd_data, shadow [256], ptr, last_rd;
   logic busy, done, nack_err, mode_serial, scl_o, scl_oe_n, sda_o, sda_oe_n, pull;
   wire scl = scl_oe_n ? 1'b1 : scl_o;
   wire sda = (sda_oe_n ? 1'b1 : sda_o) & ~pull;
   logic [7:0] q_rd [$];
   logic q_nk [$];
   int err_total = 0, checked = 0;

   i2cm_host i_dut (.mclk(mclk), .resetn(resetn), .cmd_start(cmd_start), .cmd_kind(cmd_kind),
      .fast_mode(fast_mode), .addr_sel(addr_sel), .reg_index(reg_index), .wr_data(wr_data),
      .busy(busy), .done(done), .rd_data(rd_data), .nack_err(nack_err),
      .mode_serial(mode_serial), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda),
      .sda_o(sda_o), .sda_oe_n(sda_oe_n));
   i2cm_dev_model #(.PINS(PINS)) i_dev (.scl(scl), .sda(sda), .mode(mode_serial), .pull(pull));

   // ==========================================
   initial begin
      forever #50 mclk = ~mclk;
   end

   task automatic stop_test();
      if (err_total == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic chk8(string what, logic [7:0] exp, logic [7:0] got);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic chk1(string what, logic exp, logic got);
      chk8(what, {7'h00, exp}, {7'h00, got});
   endtask

   // Notes the expectation, pulses the request, then waits a bounded time for done.
   task automatic run(i2cm_cmd_t k, logic f, logic [2:0] s, logic [7:0] idx, logic [7:0] d);
      logic hit;
      hit = (s == PINS);
      if (hit && k != CMD_READ_CUR) ptr = idx;
      if (hit && k == CMD_WRITE) shadow[idx] = d;
      if (hit && k != CMD_WRITE) last_rd = shadow[ptr];
      q_rd.push_back(last_rd);
      q_nk.push_back(!hit);
      @(posedge mclk) #10;
      {cmd_kind, fast_mode, addr_sel, reg_index, wr_data, cmd_start} = {k, f, s, idx, d, 1'b1};
      @(posedge mclk) #10;
      cmd_start = 0;
      for (int i = 0; i < 12000 && done !== 1'b1; i++) @(posedge mclk) #1;
      if (done !== 1'b1) chk1("done", 1'b1, done);
      @(posedge mclk) #10;
   endtask

   // Each done pulse retires the oldest expectation.
   always @(posedge mclk) begin
      #1;
      if (done === 1'b1) begin
         if (q_rd.size() == 0) chk1("spare done", 1'b0, 1'b1);
         else begin
            chk8("rd_data", q_rd.pop_front(), rd_data);
            chk1("nack_err", q_nk.pop_front(), nack_err);
         end
      end
   end

   // A hung frame must not stall the run forever.
   initial begin
      repeat (90000) @(posedge mclk);
      err_total++;
      stop_test();
   end

   initial begin
      for (int i = 0; i < 256; i++) shadow[i] = ~8'(i);
      ptr = 8'h00;
      last_rd = 8'h00;
      void'($urandom(32'h94AD));
      repeat (12) @(posedge mclk);
      #10 resetn = 1;
      @(posedge mclk) #10;
      chk1("mode_serial", 1'b1, mode_serial);
      run(CMD_WRITE, 1'b0, PINS, 8'h6D, 8'h92);
      run(CMD_READ_CUR, 1'b1, PINS, 8'h00, 8'h00);
      run(CMD_READ_IDX, 1'b1, PINS, 8'hFF, 8'h00);
      run(CMD_WRITE, 1'b1, PINS ^ 3'h4, 8'h10, 8'hA5);
      run(CMD_READ_IDX, 1'b1, PINS ^ 3'h1, 8'h10, 8'h00);
      run(CMD_READ_CUR, 1'b0, PINS, 8'h00, 8'h00);
      // A request while busy must vanish; a spare done would show it.
      fork
         run(CMD_READ_IDX, 1'b1, PINS, 8'h6D, 8'h00);
         begin
            repeat (40) @(posedge mclk);
            #10 cmd_start = 1;
            @(posedge mclk) #10 cmd_start = 0;
         end
      join
      for (int n = 0; n < 8; n++) begin
         run(i2cm_cmd_t'($urandom % 3), 1'($urandom), ($urandom % 4 == 0) ? PINS ^ 3'h2 : PINS,
            8'($urandom), 8'($urandom));
      end
      repeat (4) @(posedge mclk);
      stop_test();
   end
endmodule

// ---- testbench/i2cm_dev_model.sv ----
`timescale 1ns/100ps
module i2cm_dev_model #(
   parameter logic [2:0] PINS = 3'h3
) (
   input wire logic scl,
   input wire logic sda,
   input wire logic mode,
   output logic pull
);
   logic [7:0] regs [256];
   logic [7:0] sh;
   logic [7:0] ptr;
   logic hit, rw;
   int cnt, nbyte;

   // ==========================================
   // Preset contents, known to the bench as the inverse of the index.
   initial begin
      for (int i = 0; i < 256; i++) regs[i] = ~8'(i);
      ptr = 8'h00;
      pull = 1'b0;
      hit = 1'b0;
      rw = 1'b0;
      cnt = 0;
      nbyte = 0;
   end

   // Start and stop are the only data edges seen while the clock is high.
   always @(negedge sda) if (scl === 1'b1) begin
      cnt = 0;
      nbyte = 0;
      hit = 1'b0;
   end
   always @(posedge sda) if (scl === 1'b1) begin
      cnt = 0;
      hit = 1'b0;
      pull = 1'b0;
   end

   // Bits are counted and taken on the rising clock, most significant first.
   always @(posedge scl) begin
      if (cnt < 8) sh = {sh[6:0], sda};
      cnt = cnt + 1;
   end

   // The line is only touched while the clock is low; the fall that closes a start sees 0.
   always @(negedge scl) begin
      if (cnt == 8) begin
         if (nbyte == 0) begin
            hit = mode && (sh[7:1] == {4'h9, PINS});
            rw = sh[0];
         end else if (hit && !rw && nbyte == 1) ptr = sh;
         else if (hit && !rw) regs[ptr] = sh;
         pull = hit && !(rw && nbyte > 0);
      end else if (cnt == 9) begin
         cnt = 0;
         nbyte = nbyte + 1;
         pull = hit && rw && nbyte == 1 && !regs[ptr][7];
      end else if (cnt > 0) begin
         pull = hit && rw && nbyte == 1 && !regs[ptr][7-cnt];
      end
   end
endmodule

// ---- verilog/i2cm_host.sv ----
`timescale 1ns/100ps
module i2cm_host (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic cmd_start,
   input wire i2cm_pkg::i2cm_cmd_t cmd_kind,
   input wire logic fast_mode,
   input wire logic [2:0] addr_sel,
   input wire logic [7:0] reg_index,
   input wire logic [7:0] wr_data,
   output logic busy,
   output logic done,
   output logic [7:0] rd_data,
   output logic nack_err,
   output logic mode_serial,
   output logic scl_o,
   output logic scl_oe_n,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n
);
   import i2cm_pkg::*;

   // ==========================================================
   // State
   // ==========================================================
   i2cm_state_t state;
   i2cm_cmd_t kind;
   logic [1:0] phase;
   logic [3:0] bit_idx;
   logic [1:0] stage;
   logic [2:0] sel_r;
   logic [7:0] idx_r;
   logic [7:0] data_r;
   logic fast_r;
   logic [QTR_W-1:0] qcnt;
   logic [7:0] shift;
   logic ack_bad;
   logic sda_meta;
   logic sda_s;

   // ==========================================================
   // Decode
   // ==========================================================
   // Byte sequence per command; the address byte carries the fixed nibble first.
   wire [7:0] addr_w = {ADDR_FIXED, sel_r, 1'b0}; // RQ1 RQ2
   wire [7:0] addr_r = {ADDR_FIXED, sel_r, 1'b1}; // RQ1 RQ6
   wire cur_read = (kind == CMD_READ_IDX && stage == 2'd3) ||
                   (kind == CMD_READ_CUR && stage == 2'd1);
   wire [7:0] byte_s0 = (kind == CMD_READ_CUR) ? addr_r : addr_w;
   wire [7:0] byte_s2 = (kind == CMD_WRITE) ? data_r : addr_r; // RQ4 RQ6
   wire [7:0] cur_byte = (stage == 2'd0) ? byte_s0 :
                         (stage == 2'd1) ? idx_r : // RQ3
                         (stage == 2'd2) ? byte_s2 : 8'h00;
   wire [1:0] last_stage = (kind == CMD_WRITE) ? 2'd2 :
                           (kind == CMD_READ_IDX) ? 2'd3 : 2'd1;
   wire need_rs = (kind == CMD_READ_IDX) && (stage == 2'd1); // RQ6
   wire data_bit = (bit_idx != ACK_BIT);
   wire tx_bit = cur_byte[3'd7 - bit_idx[2:0]]; // RQ1
   // Host pulls SDA only for its own data bits and for the read acknowledge.
   wire pull_sda = data_bit ? (!cur_read && !tx_bit) : cur_read; // RQ7 RQ9
   wire tick = (state != ST_IDLE) && (qcnt == '0);
   wire [QTR_W-1:0] qreload = fast_r ? QTR_FAST_RELOAD : QTR_STD_RELOAD; // RQ13

   // ==========================================================
   // Pin input synchroniser
   // ==========================================================
   // The bus pin is asynchronous to mclk, so it passes two flops first.
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         sda_meta <= 1'b1;
         sda_s <= 1'b1;
      end else begin
         sda_meta <= sda_i;
         sda_s <= sda_meta;
      end
   end

   // ==========================================================
   // Quarter-bit timer
   // ==========================================================
   // SCL is made here from mclk, so the bus side needs no second domain.
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         qcnt <= '0;
      end else if (state == ST_IDLE || tick) begin
         qcnt <= qreload; // RQ13
      end else begin
         qcnt <= qcnt - 1'b1;
      end
   end

   // ==========================================================
   // Frame sequencer
   // ==========================================================
   // Start, each bit and stop walk four quarters; idle has no ticks; pin changes happen on quarter ticks.
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         state <= ST_IDLE;
         kind <= CMD_WRITE;
         phase <= 2'd0;
         bit_idx <= 4'd0;
         stage <= 2'd0;
         sel_r <= 3'd0;
         idx_r <= 8'h00;
         data_r <= 8'h00;
         fast_r <= 1'b0;
         shift <= 8'h00;
         ack_bad <= 1'b0;
         busy <= 1'b0;
         done <= 1'b0;
         rd_data <= 8'h00;
         nack_err <= 1'b0;
         mode_serial <= 1'b0;
         scl_o <= 1'b0;
         scl_oe_n <= 1'b1;
         sda_o <= 1'b0;
         sda_oe_n <= 1'b1;
      end else begin
         done <= 1'b0;
         mode_serial <= 1'b1; // RQ12
         case (state)
            ST_IDLE: begin
               // Requests that arrive while busy are simply not seen.
               if (cmd_start) begin
                  kind <= cmd_kind;
                  sel_r <= addr_sel;
                  idx_r <= reg_index;
                  data_r <= wr_data;
                  fast_r <= fast_mode;
                  stage <= 2'd0;
                  phase <= 2'd0;
                  busy <= 1'b1;
                  nack_err <= 1'b0;
                  state <= ST_START;
               end
            end
            ST_START: begin
               if (tick) begin
                  phase <= phase + 1'b1;
                  if (phase == 2'd0) begin
                     scl_oe_n <= 1'b1; // RQ11
                  end else if (phase == 2'd1) begin
                     sda_oe_n <= 1'b0; // RQ10 RQ11
                  end else if (phase == 2'd2) begin
                     scl_oe_n <= 1'b0;
                  end else begin
                     bit_idx <= 4'd0;
                     state <= ST_BIT;
                  end
               end
            end
            ST_BIT: begin
               if (tick) begin
                  phase <= phase + 1'b1;
                  if (phase == 2'd0) begin
                     sda_oe_n <= !pull_sda; // RQ9 RQ10
                  end else if (phase == 2'd1) begin
                     scl_oe_n <= 1'b1;
                  end else if (phase == 2'd2) begin
                     if (data_bit) begin
                        shift <= {shift[6:0], sda_s};
                     end
                     ack_bad <= sda_s && !cur_read;
                  end else begin
                     scl_oe_n <= 1'b0;
                     if (data_bit) begin
                        bit_idx <= bit_idx + 1'b1;
                     end else if (ack_bad) begin
                        // A missing acknowledge aborts the frame with a stop.
                        nack_err <= 1'b1;
                        state <= ST_STOP;
                     end else if (stage == last_stage) begin
                        if (cur_read) begin
                           rd_data <= shift;
                        end
                        state <= ST_STOP; // RQ8
                     end else begin
                        stage <= stage + 1'b1;
                        bit_idx <= 4'd0;
                        if (need_rs) begin
                           sda_oe_n <= 1'b1; // RQ11
                           state <= ST_START;
                        end
                     end
                  end
               end
            end
            ST_STOP: begin
               if (tick) begin
                  phase <= phase + 1'b1;
                  if (phase == 2'd0) begin
                     sda_oe_n <= 1'b0;
                  end else if (phase == 2'd1) begin
                     scl_oe_n <= 1'b1;
                  end else if (phase == 2'd2) begin
                     sda_oe_n <= 1'b1; // RQ10
                  end else begin
                     busy <= 1'b0;
                     done <= 1'b1;
                     state <= ST_IDLE;
                  end
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Assertions
   // ==========================================================
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);

   sequence s_bus_idle_high;
      scl_oe_n && sda_oe_n;
   endsequence

   sequence s_start_edge;
      scl_oe_n && $fell(sda_oe_n);
   endsequence

   property p_addr_pattern;
      (state == ST_BIT && stage == 2'd0) |-> cur_byte[7:4] == 4'h9 && cur_byte[3:1] == sel_r;
   endproperty
   a_addr_pattern: assert property (p_addr_pattern) else $error("address byte wrong"); // RQ1

   property p_write_dir;
      (state == ST_BIT && stage == 2'd0 && kind != CMD_READ_CUR) |-> !cur_byte[0];
   endproperty
   a_write_dir: assert property (p_write_dir) else $error("write bit not zero"); // RQ2

   property p_index_byte;
      (state == ST_BIT && stage == 2'd1 && kind != CMD_READ_CUR) |-> cur_byte == idx_r;
   endproperty
   a_index_byte: assert property (p_index_byte) else $error("index byte wrong"); // RQ3

   property p_msb_first;
      (state == ST_BIT && phase == 2'd2 && data_bit && !cur_read)
         |-> sda_oe_n == cur_byte[3'd7 - bit_idx[2:0]];
   endproperty
   a_msb_first: assert property (p_msb_first) else $error("data bit order wrong"); // RQ4

   // The host reads back its own byte from the wire, so a bit lost on the line shows here.
   property p_echo;
      (state == ST_BIT && !data_bit && !cur_read && phase == PH_LAST && tick)
         |-> shift == cur_byte;
   endproperty
   a_echo: assert property (p_echo) else $error("sent byte not seen on line"); // RQ1

   property p_read_dir;
      (state == ST_BIT && kind == CMD_READ_IDX && stage == 2'd2) |-> cur_byte == addr_r;
   endproperty
   a_read_dir: assert property (p_read_dir) else $error("read address wrong"); // RQ6

   property p_master_ack;
      (state == ST_BIT && !data_bit && cur_read && phase == 2'd2) |-> !sda_oe_n;
   endproperty
   a_master_ack: assert property (p_master_ack) else $error("read byte not acked"); // RQ7

   property p_release_slave;
      (state == ST_BIT && phase == 2'd2 && (data_bit == cur_read)) |-> sda_oe_n;
   endproperty
   a_release_slave: assert property (p_release_slave) else $error("SDA not released"); // RQ9

   property p_sda_scl_low;
      (state == ST_BIT && $changed(sda_oe_n)) |-> !scl_oe_n;
   endproperty
   a_sda_scl_low: assert property (p_sda_scl_low) else $error("SDA moved, SCL high"); // RQ10

   property p_rstart;
      s_start_edge |-> $past(scl_oe_n && sda_oe_n);
   endproperty
   a_rstart: assert property (p_rstart) else $error("start not from high lines"); // RQ11

   property p_stop_end;
      (state == ST_STOP && phase == 2'd3 && tick) |=> done and s_bus_idle_high;
   endproperty
   a_stop_end: assert property (p_stop_end) else $error("stop not clean"); // RQ8

   property p_fast_rate;
      (tick && fast_r && state == ST_BIT && phase != PH_LAST) |-> ##1 (!tick) [*6] ##1 tick;
   endproperty
   a_fast_rate: assert property (p_fast_rate) else $error("fast quarter wrong"); // RQ13

endmodule

// ---- verilog/i2cm_pkg.sv ----
// Operation
// RQ1: Address sent MSB first, fixed 1001 plus pins.
// RQ2: Write direction bit zero; device acknowledges.
// RQ3: Eight-bit register index follows, MSB first.
// RQ4: One data byte written, MSB first, acknowledged.
// RQ5: Device keeps pointer until reset or rewrite.
// RQ6: Read: repeated start, address, direction one.
// RQ7: Master acknowledges each read data byte.
// RQ8: Then stop, or repeated start and next.
// RQ9: Master alone clocks; device drives ack/read.
// RQ10: Data changes only with clock low.
// RQ11: Repeated start: data up, clock up, data down.
// RQ12: Device answers only with mode pin high.
// RQ13: Works at standard and fast clock rates.
// RQ14: Device ignores transfers for other addresses.
package i2cm_pkg;

   // ==========================================================
   // Bus timing
   // ==========================================================
   localparam int MCLK_KHZ = 10000;
   localparam int SCL_STD_KHZ = 100;
   localparam int SCL_FAST_KHZ = 400;
   localparam int QTR_W = 5;
   // Each bit is four quarters; rounding up keeps the bus at or below its rate.
   localparam int QTR_STD_CYC = (MCLK_KHZ + 4 * SCL_STD_KHZ - 1) / (4 * SCL_STD_KHZ);
   localparam int QTR_FAST_CYC = (MCLK_KHZ + 4 * SCL_FAST_KHZ - 1) / (4 * SCL_FAST_KHZ);
   localparam logic [QTR_W-1:0] QTR_STD_RELOAD = QTR_W'(QTR_STD_CYC - 1);
   localparam logic [QTR_W-1:0] QTR_FAST_RELOAD = QTR_W'(QTR_FAST_CYC - 1);

   // ==========================================================
   // Frame layout
   // ==========================================================
   localparam logic [3:0] ADDR_FIXED = 4'h9;
   localparam logic [3:0] ACK_BIT = 4'h8;
   localparam logic [1:0] PH_LAST = 2'h3;

   // ==========================================================
   // Types
   // ==========================================================
   typedef enum logic [1:0] {
      CMD_WRITE = 2'b00,
      CMD_READ_IDX = 2'b01,
      CMD_READ_CUR = 2'b10
   } i2cm_cmd_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_START = 2'b01,
      ST_BIT = 2'b10,
      ST_STOP = 2'b11
   } i2cm_state_t;

endpackage
